// ---- rtl/cpf_cell_protection_fsm.sv ----
`timescale 1ns/10ps
`default_nettype none
// Function
// - Overvoltage held for delay enters overcharge
// - Overcharge drives charge switch low
// - Overcharge release by selected type and delay
// - Undervoltage held for delay enters overdischarge
// - Overdischarge drives discharge switch low
// - Overdischarge pulls node up; enters standby
// - Overdischarge release by selected type, delay
// - Sense above level one enters overcurrent
// - Optional level two with own delay
// - Discharge overcurrent drives discharge switch low
// - Auto type one: pulldown, ratio release
// - Auto type two: weak pulldown, fixed release
// - Latch type: pullup, charger pulls release
// - Short needs uninterrupted short delay
// - Short: discharge low, overcurrent release
// - Negative sense held enters charge overcurrent
// - Charge overcurrent: pullup, release on removal
// - Zero-volt permitted charges with adequate charger
// - Zero-volt inhibited keeps charge switch off
module cpf_cell_protection_fsm #(
    parameter int unsigned OVC_DET_CYC = cpf_pkg::OVC_DET_CYC,
    parameter int unsigned OVC_REL_CYC = cpf_pkg::OVC_REL_CYC,
    parameter int unsigned OD_DET_CYC  = cpf_pkg::OD_DET_CYC,
    parameter int unsigned OD_REL_CYC  = cpf_pkg::OD_REL_CYC,
    parameter int unsigned DOC1_CYC    = cpf_pkg::DOC1_CYC,
    parameter int unsigned DOC2_CYC    = cpf_pkg::DOC2_CYC,
    parameter int unsigned DOC_REL_CYC = cpf_pkg::DOC_REL_CYC,
    parameter int unsigned SHORT_CYC   = cpf_pkg::SHORT_CYC,
    parameter int unsigned COC_DET_CYC = cpf_pkg::COC_DET_CYC,
    parameter int unsigned COC_REL_CYC = cpf_pkg::COC_REL_CYC
) (
    // Clock, reset and enable
    input  wire logic               sys_clk_i,
    input  wire logic               rst_n_i,
    input  wire logic               ce_i,
    // APB slave
    input  wire logic [11:0]        paddr_i,
    input  wire logic               psel_i,
    input  wire logic               penable_i,
    input  wire logic               pwrite_i,
    input  wire logic [31:0]        pwdata_i,
    output logic      [31:0]        prdata_o,
    output logic                    pready_o,
    output logic                    pslverr_o,
    // Analog side
    input  wire cpf_pkg::cpf_cmp_t  cmp_i,
    output cpf_pkg::cpf_drive_t     drive_o
);

    localparam int unsigned NT = cpf_pkg::N_TIMERS;
    localparam int unsigned LIM [NT] = '{
        OVC_DET_CYC, OVC_REL_CYC, OD_DET_CYC, OD_REL_CYC, DOC1_CYC,
        DOC2_CYC, DOC_REL_CYC, SHORT_CYC, COC_DET_CYC, COC_REL_CYC
    };

    // Comparators are asynchronous to the timebase.
    cpf_pkg::cpf_cmp_t cmp_meta;
    cpf_pkg::cpf_cmp_t cmp;

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cmp_meta <= '0;
            cmp      <= '0;
        end else if (ce_i) begin
            cmp_meta <= cmp_i;
            cmp      <= cmp_meta;
        end
    end

    // Configuration and fault state.
    logic [cpf_pkg::CTRL_W-1:0] ctrl;
    logic [cpf_pkg::CTRL_W-1:0] next_ctrl;
    logic                       ovc;
    logic                       next_ovc;
    cpf_pkg::cpf_od_state_t     od_state;
    cpf_pkg::cpf_od_state_t     next_od_state;
    logic                       doc;
    logic                       next_doc;
    logic                       short_flt;
    logic                       next_short_flt;
    logic                       coc;
    logic                       next_coc;

    logic       ovc_latch;
    logic [1:0] od_type;
    logic [1:0] doc_type;
    logic       doc2_en;
    logic       zv_inhib;
    logic       dis_fault;
    logic       od_flt;

    assign ovc_latch = ctrl[cpf_pkg::CB_OVC_LATCH];
    assign od_type   = ctrl[cpf_pkg::CB_OD_TYPE +: 2];
    assign doc_type  = ctrl[cpf_pkg::CB_DOC_TYPE +: 2];
    assign doc2_en   = ctrl[cpf_pkg::CB_DOC2_EN];
    assign zv_inhib  = ctrl[cpf_pkg::CB_ZV_INHIB];
    assign dis_fault = doc | short_flt;
    assign od_flt    = (od_state != cpf_pkg::OD_NONE);

    // Qualifying conditions for each timer.
    logic [NT-1:0] cond;
    logic [NT-1:0] done;
    logic          ovc_rel_a;
    logic          ovc_rel_b;
    logic          od_rel_a;
    logic          od_rel_b;
    logic          doc_rel;

    always_comb begin
        ovc_rel_a = !cmp.node_above_coc_rel && cmp.cell_below_ovc_rel;
        ovc_rel_b = cmp.node_above_coc_rel && !cmp.cell_above_ovc_thr;
        od_rel_a  = cmp.node_above_chg_one && cmp.cell_above_od_rel;
        od_rel_b  = !cmp.node_above_chg_one && !cmp.cell_below_od_thr;
        if (doc_type == cpf_pkg::DOC_AUTO1) begin
            doc_rel = cmp.node_below_ratio_rel;
        end else begin
            doc_rel = cmp.node_below_fixed_rel;
        end
        cond = '0;
        cond[cpf_pkg::T_OVC_DET] = !ovc && cmp.cell_above_ovc_thr;
        if (ovc_latch) begin
            cond[cpf_pkg::T_OVC_REL] = ovc && ovc_rel_b;
        end else begin
            cond[cpf_pkg::T_OVC_REL] = ovc && (ovc_rel_a || ovc_rel_b);
        end
        cond[cpf_pkg::T_OD_DET] = !od_flt && cmp.cell_below_od_thr;
        if (od_type == cpf_pkg::OD_AUTO) begin
            cond[cpf_pkg::T_OD_REL] = od_flt && (od_rel_a || od_rel_b);
        end else if (od_type == cpf_pkg::OD_LATCH1) begin
            cond[cpf_pkg::T_OD_REL] = od_flt && od_rel_b;
        end else begin
            cond[cpf_pkg::T_OD_REL] = od_flt && !cmp.node_above_chg_two;
        end
        cond[cpf_pkg::T_DOC1] = !dis_fault && cmp.sense_above_doc_one;
        cond[cpf_pkg::T_DOC2] = !dis_fault && doc2_en
                                && cmp.sense_above_doc_two;
        cond[cpf_pkg::T_DOC_REL] = dis_fault && doc_rel;
        cond[cpf_pkg::T_SHORT] = !dis_fault && cmp.sense_above_short;
        cond[cpf_pkg::T_COC_DET] = !coc && cmp.sense_below_coc;
        cond[cpf_pkg::T_COC_REL] = coc && cmp.node_above_coc_rel;
    end

    // One qualification counter per condition.
    genvar gi;
    generate
        for (gi = 0; gi < NT; gi++) begin : g_timer
            logic [31:0] cnt;
            logic [31:0] next_cnt;

            always_comb begin
                if (!cond[gi]) begin
                    next_cnt = '0;
                end else if (cnt < LIM[gi]) begin
                    next_cnt = cnt + 32'h0000_0001;
                end else begin
                    next_cnt = cnt;
                end
            end

            assign done[gi] = cond[gi] && (cnt == LIM[gi] - 1);

            always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    cnt <= '0;
                end else if (ce_i) begin
                    cnt <= next_cnt;
                end
            end
        end
    endgenerate

    // Fault state. Standby follows when the synchronised node reads above the charger level;
    // the pull-up lifts it a few cycles after entry, so only a connected charger holds it below.
    always_comb begin
        next_ovc       = ovc;
        next_od_state  = od_state;
        next_doc       = doc;
        next_short_flt = short_flt;
        next_coc       = coc;
        if (done[cpf_pkg::T_OVC_DET]) begin
            next_ovc = 1'b1;
        end else if (done[cpf_pkg::T_OVC_REL]) begin
            next_ovc = 1'b0;
        end
        case (od_state)
            cpf_pkg::OD_NONE: begin
                if (done[cpf_pkg::T_OD_DET]) begin
                    next_od_state = cpf_pkg::OD_ACTIVE;
                end
            end
            cpf_pkg::OD_ACTIVE: begin
                if (done[cpf_pkg::T_OD_REL]) begin
                    next_od_state = cpf_pkg::OD_NONE;
                end else if (cmp.node_above_chg_one) begin
                    next_od_state = cpf_pkg::OD_STANDBY;
                end
            end
            cpf_pkg::OD_STANDBY: begin
                if (done[cpf_pkg::T_OD_REL]) begin
                    next_od_state = cpf_pkg::OD_NONE;
                end
            end
            default: begin
                next_od_state = cpf_pkg::OD_NONE;
            end
        endcase
        if (done[cpf_pkg::T_DOC_REL]) begin
            next_doc       = 1'b0;
            next_short_flt = 1'b0;
        end else begin
            if (done[cpf_pkg::T_DOC1] || done[cpf_pkg::T_DOC2]) begin
                next_doc = 1'b1;
            end
            if (done[cpf_pkg::T_SHORT]) begin
                next_short_flt = 1'b1;
            end
        end
        if (done[cpf_pkg::T_COC_DET]) begin
            next_coc = 1'b1;
        end else if (done[cpf_pkg::T_COC_REL]) begin
            next_coc = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ovc       <= 1'b0;
            od_state  <= cpf_pkg::OD_NONE;
            doc       <= 1'b0;
            short_flt <= 1'b0;
            coc       <= 1'b0;
        end else if (ce_i) begin
            ovc       <= next_ovc;
            od_state  <= next_od_state;
            doc       <= next_doc;
            short_flt <= next_short_flt;
            coc       <= next_coc;
        end
    end

    // Switch and node drive. Both switches stay off through reset, but the first
    // edge after it drives them from the cleared synchroniser, before sampled comparators arrive.
    cpf_pkg::cpf_drive_t next_drive;
    logic                chg_block;
    logic                zv_block;

    always_comb begin
        if (zv_inhib) begin
            zv_block = cmp.cell_at_zero_inhibit;
        end else begin
            zv_block = cmp.cell_at_zero_inhibit
                       && !cmp.charger_above_min;
        end
        chg_block = ovc || coc || zv_block;
        next_drive.charge_switch_out    = !chg_block;
        next_drive.discharge_switch_out = !(od_flt || dis_fault);
        next_drive.node_pullup = od_flt || coc
            || (dis_fault && doc_type != cpf_pkg::DOC_AUTO1
                && doc_type != cpf_pkg::DOC_AUTO2);
        next_drive.node_pulldown_strong =
            dis_fault && doc_type == cpf_pkg::DOC_AUTO1;
        next_drive.node_pulldown_weak =
            dis_fault && doc_type == cpf_pkg::DOC_AUTO2;
        next_drive.standby = (od_state == cpf_pkg::OD_STANDBY);
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            drive_o <= '0;
        end else if (ce_i) begin
            drive_o <= next_drive;
        end
    end

    // APB slave with one wait state; read data is captured in the
    // first access cycle and pready follows one cycle later.
    logic        rdy_q;
    logic        next_rdy_q;
    logic [31:0] next_prdata;
    logic        mapped;
    logic [31:0] status;

    always_comb begin
        status = {24'h00_0000, drive_o.discharge_switch_out,
                  drive_o.charge_switch_out, coc, short_flt, doc,
                  od_state == cpf_pkg::OD_STANDBY, od_flt, ovc};
        if (paddr_i == cpf_pkg::ADDR_CTRL) begin
            mapped      = 1'b1;
            next_prdata = {25'h000_0000, ctrl};
        end else if (paddr_i == cpf_pkg::ADDR_STATUS) begin
            mapped      = 1'b1;
            next_prdata = status;
        end else begin
            mapped      = 1'b0;
            next_prdata = 32'h0000_0000;
        end
        if (!(psel_i && penable_i && !rdy_q && !pwrite_i)) begin
            next_prdata = prdata_o;
        end
        next_rdy_q = psel_i && penable_i && !rdy_q;
        next_ctrl  = ctrl;
        if (rdy_q && pwrite_i && paddr_i == cpf_pkg::ADDR_CTRL) begin
            next_ctrl = pwdata_i[cpf_pkg::CTRL_W-1:0];
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdy_q    <= 1'b0;
            prdata_o <= 32'h0000_0000;
            ctrl     <= cpf_pkg::CTRL_RESET;
        end else if (ce_i) begin
            rdy_q    <= next_rdy_q;
            prdata_o <= next_prdata;
            ctrl     <= next_ctrl;
        end
    end

    assign pready_o  = rdy_q && ce_i;
    assign pslverr_o = rdy_q && ce_i && !mapped;

endmodule : cpf_cell_protection_fsm
`default_nettype wire

// ---- rtl/cpf_pkg.sv ----
package cpf_pkg;

    // Timebase.
    localparam int unsigned CLK_KHZ = 250000;

    // Qualification times in microseconds.
    localparam int unsigned OVC_DET_US = 1000;
    localparam int unsigned OVC_REL_US = 1000;
    localparam int unsigned OD_DET_US  = 1000;
    localparam int unsigned OD_REL_US  = 1000;
    localparam int unsigned DOC1_US    = 1000;
    localparam int unsigned DOC2_US    = 100;
    localparam int unsigned DOC_REL_US = 1000;
    localparam int unsigned SHORT_US   = 100;
    localparam int unsigned COC_DET_US = 1000;
    localparam int unsigned COC_REL_US = 4000;

    // Cycle counts; a least time rounds up to whole cycles.
    function automatic int unsigned us2cyc(input int unsigned us);
        longint unsigned c;
        c = (longint'(us) * CLK_KHZ + 999) / 1000;
        return (c < 1) ? 1 : int'(c);
    endfunction : us2cyc

    localparam int unsigned OVC_DET_CYC = us2cyc(OVC_DET_US);
    localparam int unsigned OVC_REL_CYC = us2cyc(OVC_REL_US);
    localparam int unsigned OD_DET_CYC  = us2cyc(OD_DET_US);
    localparam int unsigned OD_REL_CYC  = us2cyc(OD_REL_US);
    localparam int unsigned DOC1_CYC    = us2cyc(DOC1_US);
    localparam int unsigned DOC2_CYC    = us2cyc(DOC2_US);
    localparam int unsigned DOC_REL_CYC = us2cyc(DOC_REL_US);
    localparam int unsigned SHORT_CYC   = us2cyc(SHORT_US);
    localparam int unsigned COC_DET_CYC = us2cyc(COC_DET_US);
    localparam int unsigned COC_REL_CYC = us2cyc(COC_REL_US);

    // Qualification timer indices.
    localparam int unsigned T_OVC_DET = 0;
    localparam int unsigned T_OVC_REL = 1;
    localparam int unsigned T_OD_DET  = 2;
    localparam int unsigned T_OD_REL  = 3;
    localparam int unsigned T_DOC1    = 4;
    localparam int unsigned T_DOC2    = 5;
    localparam int unsigned T_DOC_REL = 6;
    localparam int unsigned T_SHORT   = 7;
    localparam int unsigned T_COC_DET = 8;
    localparam int unsigned T_COC_REL = 9;
    localparam int unsigned N_TIMERS  = 10;

    // Register map.
    localparam logic [11:0] ADDR_CTRL   = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [6:0]  CTRL_RESET  = 7'h00;
    localparam int unsigned CTRL_W      = 7;

    // Control field positions.
    localparam int unsigned CB_OVC_LATCH = 0;
    localparam int unsigned CB_OD_TYPE   = 1;
    localparam int unsigned CB_DOC_TYPE  = 3;
    localparam int unsigned CB_DOC2_EN   = 5;
    localparam int unsigned CB_ZV_INHIB  = 6;

    // Release type encodings.
    localparam logic [1:0] OD_AUTO    = 2'h0;
    localparam logic [1:0] OD_LATCH1  = 2'h1;
    localparam logic [1:0] DOC_AUTO1  = 2'h0;
    localparam logic [1:0] DOC_AUTO2  = 2'h1;

    typedef enum logic [1:0] {
        OD_NONE,
        OD_ACTIVE,
        OD_STANDBY
    } cpf_od_state_t;

    // Comparator results from the analog front end.
    typedef struct packed {
        logic cell_above_ovc_thr;
        logic cell_below_ovc_rel;
        logic cell_below_od_thr;
        logic cell_above_od_rel;
        logic node_above_chg_one;
        logic node_above_chg_two;
        logic node_above_coc_rel;
        logic sense_above_doc_one;
        logic sense_above_doc_two;
        logic sense_above_short;
        logic sense_below_coc;
        logic node_below_ratio_rel;
        logic node_below_fixed_rel;
        logic cell_at_zero_inhibit;
        logic charger_above_min;
    } cpf_cmp_t;

    // Drive to switches and load-node resistors.
    typedef struct packed {
        logic charge_switch_out;
        logic discharge_switch_out;
        logic node_pullup;
        logic node_pulldown_strong;
        logic node_pulldown_weak;
        logic standby;
    } cpf_drive_t;

endpackage : cpf_pkg

// ---- test/cpf_analog_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module cpf_analog_model (
    // Levels set by the bench
    input  wire cpf_pkg::cpf_cmp_t   cmp_set_i,
    input  wire logic                charger_on_i,
    input  wire logic                load_on_i,
    // Drive from the protection block
    input  wire cpf_pkg::cpf_drive_t drive_i,
    output cpf_pkg::cpf_cmp_t        cmp_o
);
    logic node_high;

    // A charger drags the load node low. Otherwise the pull-up, or a load
    // with either switch open, lifts it past every node level.
    always_comb begin
        node_high = !charger_on_i && (drive_i.node_pullup || (load_on_i
            && !(drive_i.charge_switch_out && drive_i.discharge_switch_out)));
        cmp_o = cmp_set_i;
        cmp_o.node_above_chg_one = node_high;
        cmp_o.node_above_chg_two = node_high;
        cmp_o.node_above_coc_rel = node_high;
        cmp_o.node_below_ratio_rel = !node_high;
        cmp_o.node_below_fixed_rel = !node_high;
        cmp_o.charger_above_min = charger_on_i;
    end
endmodule : cpf_analog_model
`default_nettype wire

// ---- test/cpf_check_monitor.sv ----
`timescale 1ns/10ps
`default_nettype none
module cpf_check_monitor #(
    parameter int unsigned OVC_DET_CYC = 8,
    parameter int unsigned OD_DET_CYC  = 8,
    parameter int unsigned DOC1_CYC    = 8,
    parameter int unsigned DOC2_CYC    = 8,
    parameter int unsigned SHORT_CYC   = 8,
    parameter int unsigned COC_DET_CYC = 8
) (
    // Clock and reset
    input wire logic                sys_clk_i,
    input wire logic                rst_n_i,
    input wire logic                ce_i,
    // APB handshake
    input wire logic                psel_i,
    input wire logic                penable_i,
    input wire logic                pready_o,
    input wire logic                pslverr_o,
    // Analog side
    input wire cpf_pkg::cpf_cmp_t   cmp_i,
    input wire cpf_pkg::cpf_drive_t drive_o
);
    // Run lengths give a lower bound only: a late trip passes here.
    cpf_pkg::cpf_cmp_t s1;
    cpf_pkg::cpf_cmp_t s2;
    logic [5:0]        hit;
    logic [31:0]       run [6];
    logic [31:0]       next_run [6];

    assign hit = {s2.cell_above_ovc_thr, s2.sense_below_coc,
                  s2.cell_below_od_thr, s2.sense_above_doc_one,
                  s2.sense_above_doc_two, s2.sense_above_short};

    always_comb begin
        for (int i = 0; i < 6; i++) begin
            next_run[i] = hit[5 - i] ? run[i] + 32'h0000_0001 : '0;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1 <= '0;
            s2 <= '0;
            run <= '{default: '0};
        end else begin
            s1 <= cmp_i;
            s2 <= s1;
            run <= next_run;
        end
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    pready_pulse_a: assert property (pready_o |=> !pready_o)
        else $error("pready longer than one cycle");
    pready_access_a: assert property (pready_o |-> psel_i && penable_i)
        else $error("pready outside an access");
    slverr_ready_a: assert property (pslverr_o |-> pready_o)
        else $error("pslverr without pready");
    wait_state_a: assert property (psel_i && penable_i && !pready_o && ce_i
        |=> pready_o || !ce_i)
        else $error("access not answered after one wait");
    chg_fall_cause_a: assert property (
        $fell(drive_o.charge_switch_out) |-> run[0] >= OVC_DET_CYC - 1
        || run[1] >= COC_DET_CYC - 1 || s2.cell_at_zero_inhibit)
        else $error("charge switch fell too early");
    dis_fall_cause_a: assert property (
        $fell(drive_o.discharge_switch_out) |-> run[2] >= OD_DET_CYC - 1
        || run[3] >= DOC1_CYC - 1 || run[4] >= DOC2_CYC - 1
        || run[5] >= SHORT_CYC - 1)
        else $error("discharge switch fell too early");
    standby_od_a: assert property (drive_o.standby |->
        !drive_o.discharge_switch_out && drive_o.node_pullup)
        else $error("standby outside overdischarge");
    pulldown_doc_a: assert property (
        drive_o.node_pulldown_strong || drive_o.node_pulldown_weak |->
        !drive_o.discharge_switch_out && !drive_o.node_pullup
        && !(drive_o.node_pulldown_strong && drive_o.node_pulldown_weak))
        else $error("pull-down outside overcurrent");
endmodule : cpf_check_monitor

bind cpf_cell_protection_fsm cpf_check_monitor #(
    .OVC_DET_CYC(OVC_DET_CYC), .OD_DET_CYC(OD_DET_CYC),
    .DOC1_CYC(DOC1_CYC), .DOC2_CYC(DOC2_CYC), .SHORT_CYC(SHORT_CYC),
    .COC_DET_CYC(COC_DET_CYC)
) u_cpf_check_monitor (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
    .psel_i(psel_i), .penable_i(penable_i), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .cmp_i(cmp_i), .drive_o(drive_o)
);
`default_nettype wire

// ---- test/tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_mismatch++; \
    $display("[ERR] t=%0t got %0h exp %0h", $time, (a), (b)); end end
module tb_top;
    localparam int unsigned DET  = 8;
    localparam int unsigned REL  = 8;
    localparam int unsigned DOC2 = 4;
    localparam int unsigned SHRT = 6;
    localparam int unsigned CREL = 12;
    localparam logic [11:0] CTL  = cpf_pkg::ADDR_CTRL;
    localparam logic [11:0] STS  = cpf_pkg::ADDR_STATUS;

    logic                sys_clk = 1'b0;
    logic                rst_n   = 1'b0;
    logic                psel    = 1'b0;
    logic                penable = 1'b0;
    logic                pwrite  = 1'b0;
    logic [11:0]         paddr   = 12'h000;
    logic [31:0]         pwdata  = 32'h0000_0000;
    logic [31:0]         prdata;
    logic                pready;
    logic                pslverr;
    cpf_pkg::cpf_cmp_t   c       = '0;
    cpf_pkg::cpf_cmp_t   cn      = '0;
    cpf_pkg::cpf_cmp_t   cmp;
    cpf_pkg::cpf_drive_t drv;
    logic                chg_on  = 1'b0;
    logic                load_on = 1'b0;
    logic                cg      = 1'b0;
    logic                ld      = 1'b0;
    logic [31:0]         r;
    logic                e;
    int                  n_mismatch = 0;
    int                  checks     = 0;

    always #2 sys_clk = ~sys_clk;

    cpf_cell_protection_fsm #(
        .OVC_DET_CYC(DET), .OVC_REL_CYC(REL), .OD_DET_CYC(DET),
        .OD_REL_CYC(REL), .DOC1_CYC(DET), .DOC2_CYC(DOC2),
        .DOC_REL_CYC(REL), .SHORT_CYC(SHRT), .COC_DET_CYC(DET),
        .COC_REL_CYC(CREL)
    ) u_cpf_cell_protection_fsm (
        .sys_clk_i(sys_clk), .rst_n_i(rst_n), .ce_i(1'b1),
        .paddr_i(paddr), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .cmp_i(cmp), .drive_o(drv)
    );

    cpf_analog_model u_cpf_analog_model (
        .cmp_set_i(c), .charger_on_i(chg_on), .load_on_i(load_on),
        .drive_i(drv), .cmp_o(cmp)
    );

    task tally_and_finish;
        $display("checks=%0d mismatches=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            k++;
            if (k > 16) begin
                n_mismatch++;
                tally_and_finish();
            end
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task rd(input logic [11:0] a);
        apb(1'b0, a, 32'h0000_0000);
    endtask : rd

    task step;
        @(posedge sys_clk);
        c <= cn;
        chg_on <= cg;
        load_on <= ld;
    endtask : step

    task tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick

    // Counts edges from the stimulus edge until the switch reaches v.
    task sw_wait(input logic ch, input logic v, input int lo, input int hi);
        int n;
        n = 0;
        while ((ch ? drv.charge_switch_out : drv.discharge_switch_out)
               !== v) begin
            tick(1);
            n++;
            if (n > hi) begin
                n_mismatch++;
                tally_and_finish();
            end
        end
        `CHK(n >= lo, 1'b1)
    endtask : sw_wait

    task done(input string s);
        $display("test %s finished", s);
    endtask : done

    initial begin
        cn.cell_above_od_rel = 1'b1;
        cn.cell_below_ovc_rel = 1'b1;
        c = cn;
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
        tick(4);
        rd(CTL);
        `CHK(r, 32'h0000_0000)
        wr(CTL, 32'h0000_007F);
        rd(CTL);
        `CHK(r, 32'h0000_007F)
        wr(CTL, 32'h0000_0000);
        wr(STS, 32'hFFFF_FFFF);
        rd(STS);
        `CHK(r, 32'h0000_00C0)
        rd(12'h008);
        `CHK(e, 1'b1)
        `CHK(r, 32'h0000_0000)
        done("registers");
        cn.cell_above_ovc_thr = 1'b1;
        cn.cell_below_ovc_rel = 1'b0;
        step();
        tick(DET - 2);
        cn.cell_above_ovc_thr = 1'b0;
        step();
        cn.cell_above_ovc_thr = 1'b1;
        step();
        sw_wait(1'b1, 1'b0, DET + 2, DET + 4);
        cn.cell_above_ovc_thr = 1'b0;
        cn.cell_below_ovc_rel = 1'b1;
        step();
        sw_wait(1'b1, 1'b1, REL + 2, REL + 4);
        wr(CTL, 32'h0000_0001);
        cn.cell_above_ovc_thr = 1'b1;
        cn.cell_below_ovc_rel = 1'b0;
        step();
        sw_wait(1'b1, 1'b0, DET + 2, DET + 4);
        cn.cell_above_ovc_thr = 1'b0;
        cn.cell_below_ovc_rel = 1'b1;
        step();
        tick(REL + 6);
        `CHK(drv.charge_switch_out, 1'b0)
        ld = 1'b1;
        step();
        sw_wait(1'b1, 1'b1, REL + 2, REL + 4);
        ld = 1'b0;
        done("overcharge");
        wr(CTL, 32'h0000_0000);
        cn.cell_below_od_thr = 1'b1;
        cn.cell_above_od_rel = 1'b0;
        step();
        sw_wait(1'b0, 1'b0, DET + 2, DET + 4);
        tick(4);
        `CHK(drv.standby, 1'b1)
        rd(STS);
        `CHK(r, 32'h0000_0046)
        `CHK(e, 1'b0)
        cn.cell_below_od_thr = 1'b0;
        cn.cell_above_od_rel = 1'b1;
        step();
        sw_wait(1'b0, 1'b1, REL + 2, REL + 4);
        wr(CTL, 32'h0000_0004);
        cn.cell_below_od_thr = 1'b1;
        cn.cell_above_od_rel = 1'b0;
        step();
        sw_wait(1'b0, 1'b0, DET + 2, DET + 4);
        cn.cell_below_od_thr = 1'b0;
        cn.cell_above_od_rel = 1'b1;
        step();
        tick(REL + 6);
        `CHK(drv.discharge_switch_out, 1'b0)
        cg = 1'b1;
        step();
        sw_wait(1'b0, 1'b1, REL + 2, REL + 4);
        cg = 1'b0;
        done("overdischarge");
        wr(CTL, 32'h0000_0000);
        ld = 1'b1;
        cn.sense_above_doc_one = 1'b1;
        step();
        sw_wait(1'b0, 1'b0, DET + 2, DET + 4);
        cn.sense_above_doc_one = 1'b0;
        step();
        tick(REL + 6);
        `CHK(drv.discharge_switch_out, 1'b0)
        `CHK(drv.node_pulldown_strong, 1'b1)
        ld = 1'b0;
        step();
        sw_wait(1'b0, 1'b1, REL + 2, REL + 4);
        wr(CTL, 32'h0000_0028);
        ld = 1'b1;
        cn.sense_above_doc_two = 1'b1;
        step();
        sw_wait(1'b0, 1'b0, DOC2 + 2, DOC2 + 4);
        cn.sense_above_doc_two = 1'b0;
        tick(1);
        `CHK(drv.node_pulldown_weak, 1'b1)
        ld = 1'b0;
        step();
        sw_wait(1'b0, 1'b1, REL + 2, REL + 4);
        done("overcurrent");
        wr(CTL, 32'h0000_0010);
        ld = 1'b1;
        cn.sense_above_short = 1'b1;
        step();
        tick(SHRT - 2);
        cn.sense_above_short = 1'b0;
        step();
        cn.sense_above_short = 1'b1;
        step();
        sw_wait(1'b0, 1'b0, SHRT + 2, SHRT + 4);
        cn.sense_above_short = 1'b0;
        ld = 1'b0;
        step();
        tick(REL + 6);
        `CHK(drv.discharge_switch_out, 1'b0)
        `CHK(drv.node_pullup, 1'b1)
        cg = 1'b1;
        step();
        sw_wait(1'b0, 1'b1, REL + 2, REL + 4);
        done("short");
        wr(CTL, 32'h0000_0000);
        cn.sense_below_coc = 1'b1;
        step();
        sw_wait(1'b1, 1'b0, DET + 2, DET + 4);
        cn.sense_below_coc = 1'b0;
        step();
        tick(CREL + 4);
        `CHK(drv.charge_switch_out, 1'b0)
        cg = 1'b0;
        step();
        sw_wait(1'b1, 1'b1, CREL + 2, CREL + 4);
        done("charge overcurrent");
        wr(CTL, 32'h0000_0040);
        cg = 1'b1;
        cn.cell_at_zero_inhibit = 1'b1;
        step();
        sw_wait(1'b1, 1'b0, 1, 8);
        wr(CTL, 32'h0000_0000);
        sw_wait(1'b1, 1'b1, 0, 8);
        done("zero volt");
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
